// *** core/angle_range_otp.sv ***
// Angle range store with bus and pin programming and one-time burn
`timescale 1ns/1ps
`default_nettype none
module angle_range_otp #(
  parameter int SETTLE_CYC  = range_otp_pkg::SETTLE_CYCLES,
  parameter int CAPTURE_CYC = range_otp_pkg::CAPTURE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port (byte access)
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output var  logic [7:0]  regRdata,
  // Sensor side
  input  wire logic [11:0] rawAngle,
  input  wire logic        magnetDetectedFlag,
  input  wire logic        programmingOptionPin,
  input  wire logic        directionPin,
  // Output pin: open drain, enable low while driving
  input  wire logic        outPinIn,
  output var  logic        outPinOut,
  output var  logic        outPinOe_n,
  output var  logic        outPullupEn,
  output var  logic        outForcedLow,
  // Effective range for the output stage
  output var  logic [11:0] activeStart,
  output var  logic [11:0] activeSpan,
  output var  logic [13:0] activeConf
);
  // Counts below these leave no room for a capture or a settle phase
  if (SETTLE_CYC < 1 || CAPTURE_CYC < 2) begin : g_bad_counts
    $error("cycle counts too small");
  end

  // ==========================================================
  // Working and stored registers
  logic [11:0] startQ, stopQ, sizeQ;
  logic [13:0] confQ;
  logic [11:0] nvStartQ, nvStopQ, nvSizeQ;
  logic [13:0] nvConfQ;
  logic [1:0]  burnCountQ;
  logic        setBurnedQ, pinUsedQ;
  logic [1:0]  loadStepQ;
  logic        loadNow;

  function automatic logic [11:0] span(input logic [11:0] a, input logic [11:0] b, input logic dir);
    // RL6 direction pin
    span = dir ? (a - b) : (b - a);
  endfunction

  // ==========================================================
  // Pin capture
  typedef enum logic [1:0] {
    PIN_IDLE  = 2'b00,
    PIN_START = 2'b01,
    PIN_DONE  = 2'b10,
    PIN_FAIL  = 2'b11
  } pin_e;
  pin_e        pinStateQ;
  logic [31:0] lowCntQ;
  logic        lowPrevQ, pulseDone, pinCommit, zeroCommit;
  logic [11:0] pinStartQ;
  wire         pinMode = ~programmingOptionPin & ~pinUsedQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowCntQ  <= '0;
      lowPrevQ <= 1'b0;
    end else begin
      lowPrevQ <= ~outPinIn;
      if (!outPinIn && lowCntQ < CAPTURE_CYC) lowCntQ <= lowCntQ + 32'd1;
      else if (outPinIn) lowCntQ <= '0;
    end
  end
  // RL11 RL25 pulse on release
  assign pulseDone = lowPrevQ & outPinIn & (lowCntQ >= CAPTURE_CYC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinStateQ <= PIN_IDLE;
      pinStartQ <= '0;
    end else begin
      case (pinStateQ)
        // RL15 RL16 RL19 single use, magnet needed; after a size burn one pulse ends it
        PIN_IDLE:  if (pinMode && pulseDone && magnetDetectedFlag) begin
                     pinStartQ <= rawAngle;
                     pinStateQ <= setBurnedQ ? PIN_DONE : PIN_START;
                   end
        // RL12 RL14 invalid stop means failure
        PIN_START: if (pulseDone) begin
                     if (!magnetDetectedFlag || span(pinStartQ, rawAngle, directionPin) <= range_otp_pkg::MIN_RANGE)
                       pinStateQ <= PIN_FAIL;
                     else
                       pinStateQ <= PIN_DONE;
                   end
        PIN_DONE:  pinStateQ <= PIN_DONE;
        PIN_FAIL:  pinStateQ <= PIN_FAIL;
        default:   pinStateQ <= PIN_IDLE;
      endcase
    end
  end
  assign pinCommit = (pinStateQ == PIN_START) && pulseDone && magnetDetectedFlag
                     && span(pinStartQ, rawAngle, directionPin) > range_otp_pkg::MIN_RANGE;
  // RL19 zero position alone, the span comes from stop if over MIN_RANGE from the new start, else from size
  assign zeroCommit = (pinStateQ == PIN_IDLE) && pinMode && pulseDone && magnetDetectedFlag && setBurnedQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outPullupEn  <= 1'b0;
      outForcedLow <= 1'b0;
      outPinOut    <= 1'b0;
      outPinOe_n   <= 1'b1;
    end else begin
      // RL10 weak pull-up during pin programming
      outPullupEn  <= pinMode && (pinStateQ == PIN_IDLE || pinStateQ == PIN_START);
      // RL14 failure drives low
      outForcedLow <= (pinStateQ == PIN_FAIL);
      outPinOut    <= 1'b0;
      outPinOe_n   <= (pinStateQ != PIN_FAIL);
    end
  end

  // ==========================================================
  // Bus writes, burns and reload
  wire cmdWr     = regWrite && regAddr == range_otp_pkg::BURN_ADDR;
  // RL21 RL3 RL24 angle burn
  wire angleBurn = cmdWr && regWdata == range_otp_pkg::CMD_BURN_ANGLE
                   && burnCountQ < range_otp_pkg::MAX_ANGLE_BURNS && magnetDetectedFlag;
  // RL21 RL23 settings burn
  wire setBurn   = cmdWr && regWdata == range_otp_pkg::CMD_BURN_SET && !setBurnedQ;

  // RL8 three-step reload sequence
  always_ff @(posedge clk) begin
    if (!rst_n) loadStepQ <= 2'd0;
    else if (cmdWr) begin
      case (loadStepQ)
        2'd0:    loadStepQ <= (regWdata == range_otp_pkg::CMD_LOAD_1) ? 2'd1 : 2'd0;
        2'd1:    loadStepQ <= (regWdata == range_otp_pkg::CMD_LOAD_2) ? 2'd2 : 2'd0;
        default: loadStepQ <= (regWdata == range_otp_pkg::CMD_LOAD_1) ? 2'd1 : 2'd0;
      endcase
    end
  end
  assign loadNow = cmdWr && loadStepQ == 2'd2 && regWdata == range_otp_pkg::CMD_LOAD_3;

  // Stored content is not cleared by rst_n, modelling retention over power cycles
  // RL20 nonvolatile copy
  always_ff @(posedge clk) begin
    if (angleBurn || pinCommit || zeroCommit)
      nvStartQ <= pinCommit ? pinStartQ : (zeroCommit ? rawAngle : startQ);
    if (angleBurn || pinCommit)
      nvStopQ  <= pinCommit ? rawAngle : stopQ;
    if (setBurn) begin
      // RL22 size only with zero count
      if (burnCountQ == 2'd0) nvSizeQ <= sizeQ;
      nvConfQ <= confQ;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burnCountQ <= '0;
      setBurnedQ <= 1'b0;
      pinUsedQ   <= 1'b0;
    end else begin
      // RL3 count saturates so a fourth burn cannot wrap it back to zero
      if ((angleBurn || pinCommit || zeroCommit) && burnCountQ < range_otp_pkg::MAX_ANGLE_BURNS)
        burnCountQ <= burnCountQ + 2'd1;
      if (setBurn) setBurnedQ <= 1'b1;
      if (pinStateQ == PIN_DONE || pinStateQ == PIN_FAIL) pinUsedQ <= 1'b1;
    end
  end

  // RL2 RL4 RL5 RL17 working registers, reload wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startQ <= '0;
      stopQ  <= '0;
      sizeQ  <= range_otp_pkg::FULL_RANGE;
      confQ  <= '0;
    end else if (loadNow) begin
      startQ <= nvStartQ;
      stopQ  <= nvStopQ;
      sizeQ  <= nvSizeQ;
      confQ  <= nvConfQ;
    end else if (pinCommit) begin
      startQ <= pinStartQ;
      stopQ  <= rawAngle;
    end else if (zeroCommit) begin
      startQ <= rawAngle;
    end else if (regWrite) begin
      case (regAddr)
        range_otp_pkg::START_HI_ADDR: startQ[11:8] <= regWdata[3:0];
        range_otp_pkg::START_LO_ADDR: startQ[7:0]  <= regWdata;
        range_otp_pkg::STOP_HI_ADDR:  stopQ[11:8]  <= regWdata[3:0];
        range_otp_pkg::STOP_LO_ADDR:  stopQ[7:0]   <= regWdata;
        range_otp_pkg::SIZE_HI_ADDR:  sizeQ[11:8]  <= regWdata[3:0];
        range_otp_pkg::SIZE_LO_ADDR:  sizeQ[7:0]   <= regWdata;
        range_otp_pkg::CONFIGURATION_REGISTER_HI_ADDR:  confQ[13:8]  <= regWdata[5:0];
        range_otp_pkg::CONFIGURATION_REGISTER_LO_ADDR:  confQ[7:0]   <= regWdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Settle delay before the output sees new values
  logic [31:0] settleQ;
  logic        changedQ;
  wire         anyChange = regWrite || pinCommit || zeroCommit;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settleQ  <= '0;
      changedQ <= 1'b0;
    end else if (anyChange) begin
      settleQ  <= '0;
      changedQ <= 1'b1;
    end else if (changedQ && settleQ < SETTLE_CYC) begin
      settleQ <= settleQ + 32'd1;
    end else if (changedQ) begin
      changedQ <= 1'b0;
    end
  end

  // RL9 RL13 RL1 publish after settle, stop wins if its span from start exceeds MIN_RANGE
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      activeStart <= '0;
      activeSpan  <= range_otp_pkg::FULL_RANGE;
      activeConf  <= '0;
    end else if (changedQ && settleQ >= SETTLE_CYC) begin
      activeStart <= startQ;
      activeConf  <= confQ;
      if (stopQ != startQ && span(startQ, stopQ, directionPin) > range_otp_pkg::MIN_RANGE)
        activeSpan <= span(startQ, stopQ, directionPin);
      else if (sizeQ == range_otp_pkg::FULL_RANGE || sizeQ > range_otp_pkg::MIN_RANGE)
        activeSpan <= sizeQ;
    end
  end

  // ==========================================================
  // Read data, registered
  always_ff @(posedge clk) begin
    if (!rst_n) regRdata <= '0;
    else if (regRead) begin
      case (regAddr)
        range_otp_pkg::COUNT_ADDR:    regRdata <= {6'h00, burnCountQ};
        range_otp_pkg::START_HI_ADDR: regRdata <= {4'h0, startQ[11:8]};
        range_otp_pkg::START_LO_ADDR: regRdata <= startQ[7:0];
        range_otp_pkg::STOP_HI_ADDR:  regRdata <= {4'h0, stopQ[11:8]};
        range_otp_pkg::STOP_LO_ADDR:  regRdata <= stopQ[7:0];
        range_otp_pkg::SIZE_HI_ADDR:  regRdata <= {4'h0, sizeQ[11:8]};
        range_otp_pkg::SIZE_LO_ADDR:  regRdata <= sizeQ[7:0];
        range_otp_pkg::CONFIGURATION_REGISTER_HI_ADDR:  regRdata <= {2'h0, confQ[13:8]};
        range_otp_pkg::CONFIGURATION_REGISTER_LO_ADDR:  regRdata <= confQ[7:0];
        range_otp_pkg::STATUS_ADDR:   regRdata <= 8'(magnetDetectedFlag) << range_otp_pkg::STATUS_MD_BIT;
        default:                      regRdata <= 8'h00;
      endcase
    end
  end
endmodule // angle_range_otp
`default_nettype wire

// *** core/range_otp_pkg.sv ***
// Constants for the angle range one-time-programmable store
// How it works
// RL1 - Range between start and stop must exceed 18 degrees, output scaled across it
// RL2 - Range comes from start plus either stop or range size
// RL3 - Start/stop burn accepted at most 3 times in a lifetime; the code's count clears on rst_n and does not gate pin programming
// RL4 - Host reads raw angle, writes start register, waits 1 ms
// RL5 - Host reads raw angle at stop, writes stop register, waits 1 ms
// RL6 - Rotation start to stop follows the direction pin
// RL7 - Host waits 1 ms after the start/stop burn
// RL8 - Writes 0x01, 0x11, 0x10 reload stored content into readable registers
// RL9 - New settings reach the output no sooner than 1 ms after the command
// RL10 - Option pin grounded: output weakly pulled high until pin programming ends
// RL11 - Output held low 100 ms captures start, second pulse captures stop
// RL12 - Without a second pulse no permanent write happens
// RL13 - After the second pulse the new range takes effect
// RL14 - Pin programming failure drives output low forever, success follows magnet; the code's failure state clears on rst_n and success leaves the pin undriven
// RL15 - Pin programming allowed only once; the code's used flag clears on rst_n
// RL16 - Pin programming allowed only while magnet is detected
// RL17 - Host writes range size and configuration, waits 1 ms, burns settings
// RL18 - Host waits 1 ms after settings burn, then verifies by reload
// RL19 - After a size burn, zero position may still be programmed by pin or bus
// RL20 - Burned start and stop survive power cycle and read back unchanged
// RL21 - Command 0x80 burns start/stop, 0x40 burns settings, at register 0xff
// RL22 - Range size burned only while start/stop burn count is zero
// RL23 - Settings burn accepted only once in a lifetime; the code's flag clears on rst_n
// RL24 - Start/stop burn executes only when the magnet is detected
// RL25 - Output low pulses shorter than capture minimum are ignored
`default_nettype none
package range_otp_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] START_HI_ADDR  = 8'h01;
  localparam logic [7:0] START_LO_ADDR  = 8'h02;
  localparam logic [7:0] STOP_HI_ADDR   = 8'h03;
  localparam logic [7:0] STOP_LO_ADDR   = 8'h04;
  localparam logic [7:0] SIZE_HI_ADDR   = 8'h05;
  localparam logic [7:0] SIZE_LO_ADDR   = 8'h06;
  localparam logic [7:0] CONFIGURATION_REGISTER_HI_ADDR   = 8'h07;
  localparam logic [7:0] CONFIGURATION_REGISTER_LO_ADDR   = 8'h08;
  localparam logic [7:0] COUNT_ADDR     = 8'h00;
  localparam logic [7:0] STATUS_ADDR    = 8'h0b;
  localparam logic [7:0] BURN_ADDR      = 8'hff;
  // ==========================================================
  // Commands
  localparam logic [7:0] CMD_BURN_ANGLE = 8'h80;
  localparam logic [7:0] CMD_BURN_SET   = 8'h40;
  localparam logic [7:0] CMD_LOAD_1     = 8'h01;
  localparam logic [7:0] CMD_LOAD_2     = 8'h11;
  localparam logic [7:0] CMD_LOAD_3     = 8'h10;
  // ==========================================================
  // Field positions and limits
  localparam int         STATUS_MD_BIT  = 5;
  localparam logic [1:0] MAX_ANGLE_BURNS = 2'd3;
  // 18 degrees of 4096 steps per turn, rounded down: range must exceed this
  localparam logic [11:0] MIN_RANGE     = 12'h0cc;
  localparam logic [11:0] FULL_RANGE    = 12'h000;
  // ==========================================================
  // Timing
  localparam int CLK_NS         = 10;
  localparam int SETTLE_MS      = 1;
  localparam int CAPTURE_MS     = 100;
  localparam int SETTLE_CYCLES  = SETTLE_MS * 1000000 / CLK_NS;
  localparam int CAPTURE_CYCLES = CAPTURE_MS * 1000000 / CLK_NS;
endpackage : range_otp_pkg
`default_nettype wire

// *** tb/angle_range_otp_properties.sv ***
// Port checker for the angle range store
`timescale 1ns/1ps
`default_nettype none
module angle_range_otp_properties #(
  parameter int SETTLE_CYC  = 20,
  parameter int CAPTURE_CYC = 50
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // Pins and results
  input wire logic        programmingOptionPin,
  input wire logic        outPinOut,
  input wire logic        outPinOe_n,
  input wire logic        outPullupEn,
  input wire logic        outForcedLow,
  input wire logic [11:0] activeStart,
  input wire logic [11:0] activeSpan,
  input wire logic [13:0] activeConf
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Quiet cycles since the last write, saturating to keep it small
  int idleQ;
  always_ff @(posedge clk) begin
    if (!rst_n || regWrite) idleQ <= 0;
    else if (idleQ < SETTLE_CYC) idleQ <= idleQ + 1;
  end
  // ==========================================================
  // Assertions
  AST_FORCED_HOLD: assert property (outForcedLow |=> outForcedLow)
    else $error("forced low released");
  AST_FORCED_DRIVE: assert property (outForcedLow |-> !outPinOe_n && !outPinOut)
    else $error("failed pin not driven low");
  AST_OE_CAUSE: assert property (!outPinOe_n |-> outForcedLow)
    else $error("pin driven without failure");
  AST_PULLUP_OPT: assert property (outPullupEn |-> !programmingOptionPin)
    else $error("pull-up on with option pin high");
  AST_NO_OPT_FAIL: assert property (programmingOptionPin |-> !outForcedLow)
    else $error("pin failure without option pin");
  AST_SETTLE_START: assert property ($changed(activeStart) |-> idleQ >= SETTLE_CYC - 1)
    else $error("start published too early");
  AST_SETTLE_RANGE: assert property ($changed(activeSpan) || $changed(activeConf) |-> idleQ >= SETTLE_CYC - 1)
    else $error("range published too early");
  AST_READ_ANSWER: assert property ($changed(regRdata) |-> $past(regRead))
    else $error("read data moved without read");
  AST_READ_HOLD: assert property (regRead ##1 !regRead [*3] |=> $stable(regRdata))
    else $error("read data not held");
  cover property ($rose(outForcedLow));
  cover property ($fell(outPullupEn));
  cover property ($changed(activeStart));
endmodule // angle_range_otp_properties
bind angle_range_otp angle_range_otp_properties #(.SETTLE_CYC(SETTLE_CYC), .CAPTURE_CYC(CAPTURE_CYC)) i_props (
  .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .programmingOptionPin(programmingOptionPin), .outPinOut(outPinOut), .outPinOe_n(outPinOe_n),
  .outPullupEn(outPullupEn), .outForcedLow(outForcedLow), .activeStart(activeStart),
  .activeSpan(activeSpan), .activeConf(activeConf));
`default_nettype wire

// *** tb/pin_partner.sv ***
// Far side of the output pin: wire level plus the programming tool
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Clock
  input  wire logic clk,
  // Tool request and device drive
  input  wire logic pullReq,
  input  wire logic dutOe_n,
  input  wire logic dutOut,
  input  wire logic pullupEn,
  // Resolved level
  output var  logic pinLevel
);
  // Unpulled wire wanders, so no one may lean on its last level
  logic floatQ = 1'b0;
  always_ff @(posedge clk) floatQ <= ~floatQ;
  assign pinLevel = (pullReq || (!dutOe_n && !dutOut)) ? 1'b0 : (pullupEn ? 1'b1 : floatQ);
endmodule // pin_partner
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the angle range store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SC = 20;
  localparam int CC = 50;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic [7:0]  regRdata;
  logic [7:0]  rdVal;
  logic [11:0] rawAngle = 12'h000;
  logic [11:0] actStart;
  logic [11:0] actSpan;
  logic [13:0] actConf;
  logic        dirPin = 1'b0;
  logic        magnet = 1'b1;
  logic        optPin = 1'b1;
  logic        pullReq = 1'b0;
  logic        pinLevel;
  logic        pinOut;
  logic        pinOe_n;
  logic        pullupEn;
  logic        forcedLow;
  int          fail_count = 0;
  int          checks_done = 0;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end
  angle_range_otp #(.SETTLE_CYC(SC), .CAPTURE_CYC(CC)) i_dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .rawAngle(rawAngle),
    .magnetDetectedFlag(magnet), .programmingOptionPin(optPin), .directionPin(dirPin), .outPinIn(pinLevel),
    .outPinOut(pinOut), .outPinOe_n(pinOe_n), .outPullupEn(pullupEn), .outForcedLow(forcedLow),
    .activeStart(actStart), .activeSpan(actSpan), .activeConf(actConf));
  pin_partner i_pin (.clk(clk), .pullReq(pullReq), .dutOe_n(pinOe_n), .dutOut(pinOut),
    .pullupEn(pullupEn), .pinLevel(pinLevel));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Bus and pin tasks
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    rdVal = regRdata;
  endtask
  task automatic wr12(input logic [7:0] a, input logic [11:0] v);
    wr(a, {4'h0, v[11:8]});
    wr(a + 8'h01, v[7:0]);
  endtask
  task automatic chk12(input logic [7:0] a, input logic [11:0] e);
    logic [3:0] hi;
    rd(a);
    hi = rdVal[3:0];
    rd(a + 8'h01);
    `CHK("word", e, {hi, rdVal})
  endtask
  task automatic reload;
    wr(8'hff, 8'h01);
    wr(8'hff, 8'h11);
    wr(8'hff, 8'h10);
  endtask
  // host keeps the settle time on both sides of a burn
  task automatic burn(input logic [7:0] c);
    idle(SC + 2);
    wr(8'hff, c);
    idle(SC + 2);
  endtask
  task automatic pulse(input int n);
    @(negedge clk);
    pullReq = 1'b1;
    idle(n);
    pullReq = 1'b0;
    idle(4);
  endtask
  task automatic rstDut(input logic opt);
    rst_n = 1'b0;
    optPin = opt;
    idle(16);
    rst_n = 1'b1;
    idle(2);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_bus;
    `CHK("oe", 1'b1, pinOe_n)
    wr12(8'h01, 12'h123);
    wr12(8'h03, 12'h456);
    idle(SC - 2);
    `CHK("early", 12'h000, actStart)
    idle(6);
    `CHK("start", 12'h123, actStart)
    `CHK("span", 12'h333, actSpan)
    dirPin = 1'b1;
    wr(8'h04, 8'h56);
    idle(SC + 4);
    `CHK("span", 12'hccd, actSpan)
    dirPin = 1'b0;
  endtask
  task automatic t_burn;
    magnet = 1'b0;
    burn(8'h80);
    rd(8'h00);
    `CHK("count", 8'h00, rdVal)
    magnet = 1'b1;
    burn(8'h80);
    rd(8'h00);
    `CHK("count", 8'h01, rdVal)
    wr12(8'h01, 12'h777);
    reload;
    chk12(8'h01, 12'h123);
    repeat (3) burn(8'h80);
    rd(8'h00);
    `CHK("count", 8'h03, rdVal)
    rstDut(1'b1);
    reload;
    chk12(8'h01, 12'h123);
    chk12(8'h03, 12'h456);
  endtask
  task automatic t_setting;
    wr12(8'h05, 12'h400);
    wr(8'h07, 8'h21);
    wr(8'h08, 8'h5a);
    burn(8'h40);
    wr12(8'h05, 12'h200);
    burn(8'h40);
    reload;
    chk12(8'h05, 12'h400);
    chk12(8'h07, 12'h15a);
    idle(SC + 4);
    `CHK("configuration_register", 14'h215a, actConf)
    rstDut(1'b1);
    burn(8'h80);
    wr12(8'h05, 12'h300);
    burn(8'h40);
    reload;
    chk12(8'h05, 12'h400);
    idle(SC + 4);
    `CHK("span", 12'h400, actSpan)
    optPin = 1'b0;
    rawAngle = 12'h345;
    pulse(CC + 2);
    reload;
    chk12(8'h01, 12'h345);
  endtask
  task automatic t_pin;
    rstDut(1'b0);
    `CHK("pullup", 1'b1, pullupEn)
    magnet = 1'b0;
    rawAngle = 12'h040;
    pulse(CC + 2);
    magnet = 1'b1;
    rawAngle = 12'h050;
    pulse(CC / 2);
    rawAngle = 12'h100;
    pulse(CC + 2);
    rd(8'h00);
    `CHK("count", 8'h00, rdVal)
    rawAngle = 12'h300;
    pulse(CC + 2);
    idle(SC + 8);
    `CHK("start", 12'h100, actStart)
    `CHK("span", 12'h200, actSpan)
    `CHK("pullup", 1'b0, pullupEn)
    rawAngle = 12'h500;
    pulse(CC + 2);
    pulse(CC + 2);
    idle(SC + 8);
    `CHK("start", 12'h100, actStart)
  endtask
  task automatic t_fail;
    rstDut(1'b0);
    rawAngle = 12'h100;
    pulse(CC + 2);
    rawAngle = 12'h1cc;
    pulse(CC + 2);
    `CHK("forced", 1'b1, forcedLow)
    `CHK("pin", 1'b0, pinLevel)
  endtask
  initial begin
    rstDut(1'b1);
    t_bus;
    t_burn;
    t_setting;
    t_pin;
    t_fail;
    test_done;
  end
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
